// ===== aosc_checker.sv
// Assertions on relay output 0 of the switch control
`timescale 1ns/100ps
module aosc_checker
   import aosc_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // Inputs
   input wire logic is_day,
   input wire logic charge_update,
   input wire logic ctrl_by_soc,
   input wire logic [AOSC_MIN_W-1:0] minute_of_day,
   input wire logic [AOSC_MEAS_W-1:0] batt_voltage,
   input wire logic [AOSC_MEAS_W-1:0] batt_soc,
   input wire logic [AOSC_NUM_OUT-1:0][1:0] out_mode,
   input wire logic [AOSC_NUM_OUT-1:0][AOSC_FN_W-1:0] func_en,
   input wire logic [AOSC_NUM_OUT-1:0][AOSC_MEAS_W-1:0] exc_thresh,
   input wire logic [AOSC_NUM_OUT-1:0][AOSC_MEAS_W-1:0] exc_hyst,
   input wire logic [AOSC_NUM_OUT-1:0][AOSC_MEAS_W-1:0] gen_thresh,
   input wire logic [AOSC_NUM_OUT-1:0][AOSC_MEAS_W-1:0] gen_hyst,
   // Outputs
   input wire logic [AOSC_NUM_OUT-1:0] relay_on,
   input wire logic [AOSC_NUM_OUT-1:0][AOSC_FN_W-1:0] func_req,
   input wire logic [AOSC_NUM_OUT-1:0] dd_blocked,
   input wire logic dawn_known,
   input wire logic [AOSC_MIN_W-1:0] dawn_minute
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);
   // One bit wider so threshold plus hysteresis cannot wrap
   wire logic [16:0] meas = {1'b0, (ctrl_by_soc ? batt_soc : batt_voltage)};
   wire logic        fn_on = |(func_req[0] & func_en[0]);
   wire logic        auto0 = out_mode[0] == AOSC_MODE_AUTO;

   AST_EXC_ON: assert property (charge_update && meas >= exc_thresh[0]
      |=> func_req[0][1]) else $error("excess request not set");
   AST_EXC_OFF: assert property (charge_update && meas + {1'b0, exc_hyst[0]} < exc_thresh[0]
      |=> !func_req[0][1]) else $error("excess request not cleared");
   AST_GEN_ON: assert property (charge_update && meas < gen_thresh[0] |=> func_req[0][2])
      else $error("generator request not set");
   AST_GEN_OFF: assert property (charge_update && meas >= gen_thresh[0] + gen_hyst[0]
      |=> !func_req[0][2]) else $error("generator request not cleared");
   AST_HOLD: assert property (!charge_update |=> $stable(func_req[0][2:1]))
      else $error("charge functions moved without a sample");
   AST_MODE_ON: assert property (out_mode[0] == AOSC_MODE_ON |=> relay_on[0])
      else $error("permanent on not followed");
   AST_FN_OR: assert property (auto0 && !dd_blocked[0] && fn_on |=> relay_on[0])
      else $error("enabled request not on relay");
   AST_FN_NONE: assert property (auto0 && !fn_on |=> !relay_on[0])
      else $error("relay on without enabled request");
   AST_DD: assert property (auto0 && dd_blocked[0] |=> !relay_on[0])
      else $error("relay on while deep discharge trip");
   AST_ML_GATE: assert property (!dawn_known |-> !func_req[0][0])
      else $error("morning light before dawn learned");
   AST_DAWN_OFF: assert property ($rose(is_day) |-> ##[1:2] !func_req[0][0])
      else $error("morning light not ended at dawn");
   AST_DAWN_LOAD: assert property (dawn_known && $rose(is_day)
      |=> dawn_minute == $past(minute_of_day)) else $error("dawn time not refreshed");
endmodule : aosc_checker

bind aosc_top aosc_checker u_aosc_checker (.ref_clk(ref_clk), .reset(reset), .is_day(is_day),
   .charge_update(charge_update), .ctrl_by_soc(ctrl_by_soc), .minute_of_day(minute_of_day),
   .batt_voltage(batt_voltage), .batt_soc(batt_soc), .out_mode(out_mode), .func_en(func_en),
   .exc_thresh(exc_thresh), .exc_hyst(exc_hyst), .gen_thresh(gen_thresh), .gen_hyst(gen_hyst),
   .relay_on(relay_on), .func_req(func_req), .dd_blocked(dd_blocked),
   .dawn_known(dawn_known), .dawn_minute(dawn_minute));

// ===== aosc_hyst.sv
// Threshold comparator with hysteresis, updated on each charge-state sample
`timescale 1ns/100ps
module aosc_hyst (
   // Clock and reset
   input  wire logic                            ref_clk,
   input  wire logic                            reset,
   // Sample and settings
   input  wire logic                            update,
   input  wire logic                            low_side,
   input  wire logic [aosc_pkg::AOSC_MEAS_W-1:0] meas,
   input  wire logic [aosc_pkg::AOSC_MEAS_W-1:0] thresh,
   input  wire logic [aosc_pkg::AOSC_MEAS_W-1:0] hyst,
   // Result
   output logic                                 active
);
   import aosc_pkg::*;

   logic                   next_active;
   logic [AOSC_MEAS_W:0]   upper;
   logic [AOSC_MEAS_W-1:0] lower;

   // Widened upper and saturating lower bound so a large hysteresis cannot wrap the window
   always_comb begin
      upper = {1'b0, thresh} + {1'b0, hyst};
      lower = (thresh >= hyst) ? (thresh - hyst) : AOSC_MEAS_ZERO;
   end

   always_comb begin
      next_active = active;
      if (update) begin
         if (low_side) begin
            if (active) begin
               if ({1'b0, meas} >= upper) begin
                  next_active = 1'b0;
               end
            end else if (meas < thresh) begin
               next_active = 1'b1;
            end
         end else begin
            if (active) begin
               if (meas < lower) begin
                  next_active = 1'b0;
               end
            end else if (meas >= thresh) begin
               next_active = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         active <= 1'b0;
      end else begin
         active <= next_active;
      end
   end

endmodule : aosc_hyst

// ===== aosc_load_model.sv
// Relay contact model: each load follows its relay request one cycle late
`timescale 1ns/100ps
module aosc_load_model (
   // Clock
   input  wire logic       ref_clk,
   // Relay drive and load state
   input  wire logic [2:0] relay_on,
   output logic      [2:0] load_on
);
   // Pull-in takes one cycle, contact bounce is not modelled
   always_ff @(posedge ref_clk) begin
      load_on <= relay_on;
   end
endmodule : aosc_load_model

// ===== aosc_pkg.sv
// Shared constants, types and helpers of the auxiliary output switch control
package aosc_pkg;

   // Structure of the block
   localparam int AOSC_NUM_OUT   = 3;
   localparam int AOSC_NUM_TIMER = 4;
   localparam int AOSC_NUM_DAY   = 7;
   localparam int AOSC_MIN_W     = 11;
   localparam int AOSC_MEAS_W    = 16;
   localparam int AOSC_DAY_W     = 3;

   // Minutes in one day, the wrap point of the time-of-day counter
   localparam logic [AOSC_MIN_W-1:0] AOSC_MIN_PER_DAY = 11'h5a0;

   // Bit positions in the per-output function enable and request vectors
   localparam int AOSC_FN_MORNING = 0;
   localparam int AOSC_FN_EXCESS  = 1;
   localparam int AOSC_FN_GEN     = 2;
   localparam int AOSC_FN_TIMER0  = 3;
   localparam int AOSC_FN_W       = AOSC_FN_TIMER0 + AOSC_NUM_TIMER;

   // Operating mode codes of each output
   localparam logic [1:0] AOSC_MODE_OFF  = 2'h0;
   localparam logic [1:0] AOSC_MODE_ON   = 2'h1;
   localparam logic [1:0] AOSC_MODE_AUTO = 2'h2;

   // Reset values
   localparam logic [AOSC_MIN_W-1:0]  AOSC_MIN_RST  = 11'h000;
   localparam logic [AOSC_MEAS_W-1:0] AOSC_MEAS_ZERO = 16'h0000;

   // Dawn learning states
   typedef enum logic [2:0] {
      AOSC_DAWN_INIT  = 3'b001,
      AOSC_DAWN_NIGHT = 3'b010,
      AOSC_DAWN_KNOWN = 3'b100
   } aosc_dawn_type;

   // Time of day a minus b, wrapped into one day
   function automatic logic [AOSC_MIN_W-1:0] aosc_min_sub(
      input logic [AOSC_MIN_W-1:0] a,
      input logic [AOSC_MIN_W-1:0] b
   );
      logic [AOSC_MIN_W:0] wrap;
      wrap = {1'b0, a} + {1'b0, AOSC_MIN_PER_DAY} - {1'b0, b};
      if (a >= b) begin
         return a - b;
      end
      return wrap[AOSC_MIN_W-1:0];
   endfunction : aosc_min_sub

endpackage : aosc_pkg

// ===== aosc_top.sv
// Auxiliary output switch control: three relay outputs and their functions
//
// Notes on behaviour
// - Morning light stays on for its duration, ending the off-delay before dawn.
// - Dawn forces the morning-light output off at once.
// - Morning light waits until one full night-to-day change was seen.
// - Every later dawn refreshes the learned dawn time.
// - Excess energy turns on when charge reaches its start threshold.
// - Excess energy turns off below start threshold minus hysteresis.
// - Thresholds are volts under voltage control, percent under charge control.
// - Generator turns on when charge falls below its start threshold.
// - Generator turns off when charge reaches threshold plus hysteresis.
// - Four independent weekly timers switch each output.
// - Each timer has its own on and off time per weekday.
// - On and off events match separately, so intervals may span days.
// - Enabled functions are ORed; off only when all request off.
// - In automatic mode, deep discharge protection forces off until reconnection hysteresis is met.
// - Each output is permanently on, permanently off or automatic.
// - Functions act on an output only in automatic mode.
`timescale 1ns/100ps
module aosc_top (
   // Clock and reset
   input  wire logic ref_clk,
   input  wire logic reset,

   // Brightness from the solar input, high while it is day
   input  wire logic is_day,

   // Calendar time
   input  wire logic                           minute_tick,
   input  wire logic [aosc_pkg::AOSC_DAY_W-1:0] weekday,
   input  wire logic [aosc_pkg::AOSC_MIN_W-1:0] minute_of_day,

   // Battery charge state
   input  wire logic                             charge_update,
   input  wire logic                             ctrl_by_soc,
   input  wire logic [aosc_pkg::AOSC_MEAS_W-1:0] batt_voltage,
   input  wire logic [aosc_pkg::AOSC_MEAS_W-1:0] batt_soc,

   // Operating mode and function enables per output
   input  wire logic [aosc_pkg::AOSC_NUM_OUT-1:0][1:0]                  out_mode,
   input  wire logic [aosc_pkg::AOSC_NUM_OUT-1:0][aosc_pkg::AOSC_FN_W-1:0] func_en,

   // Morning light settings per output
   input  wire logic [aosc_pkg::AOSC_NUM_OUT-1:0][aosc_pkg::AOSC_MIN_W-1:0] ml_on_dur,
   input  wire logic [aosc_pkg::AOSC_NUM_OUT-1:0][aosc_pkg::AOSC_MIN_W-1:0] ml_off_delay,

   // Charge thresholds and hysteresis per output
   input  wire logic [aosc_pkg::AOSC_NUM_OUT-1:0][aosc_pkg::AOSC_MEAS_W-1:0] exc_thresh,
   input  wire logic [aosc_pkg::AOSC_NUM_OUT-1:0][aosc_pkg::AOSC_MEAS_W-1:0] exc_hyst,
   input  wire logic [aosc_pkg::AOSC_NUM_OUT-1:0][aosc_pkg::AOSC_MEAS_W-1:0] gen_thresh,
   input  wire logic [aosc_pkg::AOSC_NUM_OUT-1:0][aosc_pkg::AOSC_MEAS_W-1:0] gen_hyst,
   input  wire logic [aosc_pkg::AOSC_NUM_OUT-1:0][aosc_pkg::AOSC_MEAS_W-1:0] dd_thresh,
   input  wire logic [aosc_pkg::AOSC_NUM_OUT-1:0][aosc_pkg::AOSC_MEAS_W-1:0] dd_hyst,

   // Weekly timer settings per output, timer and weekday
   input  wire logic [aosc_pkg::AOSC_NUM_OUT-1:0][aosc_pkg::AOSC_NUM_TIMER-1:0]
                     [aosc_pkg::AOSC_NUM_DAY-1:0]                        tm_on_day,
   input  wire logic [aosc_pkg::AOSC_NUM_OUT-1:0][aosc_pkg::AOSC_NUM_TIMER-1:0]
                     [aosc_pkg::AOSC_NUM_DAY-1:0][aosc_pkg::AOSC_MIN_W-1:0] tm_on_time,
   input  wire logic [aosc_pkg::AOSC_NUM_OUT-1:0][aosc_pkg::AOSC_NUM_TIMER-1:0]
                     [aosc_pkg::AOSC_NUM_DAY-1:0]                        tm_off_day,
   input  wire logic [aosc_pkg::AOSC_NUM_OUT-1:0][aosc_pkg::AOSC_NUM_TIMER-1:0]
                     [aosc_pkg::AOSC_NUM_DAY-1:0][aosc_pkg::AOSC_MIN_W-1:0] tm_off_time,

   // Relay requests and status
   output wire logic [aosc_pkg::AOSC_NUM_OUT-1:0]                     relay_on,
   output wire logic [aosc_pkg::AOSC_NUM_OUT-1:0][aosc_pkg::AOSC_FN_W-1:0] func_req,
   output wire logic [aosc_pkg::AOSC_NUM_OUT-1:0]                     dd_blocked,
   output wire logic                                                  dawn_known,
   output wire logic [aosc_pkg::AOSC_MIN_W-1:0]                       dawn_minute
);
   import aosc_pkg::*;

   // One timer event for today: day enabled and minute matched
   function automatic logic tm_hit(
      input logic [AOSC_NUM_DAY-1:0]                 day_en,
      input logic [AOSC_NUM_DAY-1:0][AOSC_MIN_W-1:0] at_min,
      input logic [AOSC_DAY_W-1:0]                   wd,
      input logic [AOSC_MIN_W-1:0]                   now
   );
      // A weekday code outside the week never matches
      if (wd >= AOSC_DAY_W'(AOSC_NUM_DAY)) begin
         return 1'b0;
      end
      return day_en[wd] && (now == at_min[wd]);
   endfunction : tm_hit

   // Dawn learning, shared by all outputs
   aosc_dawn_type          dawn_state;
   aosc_dawn_type          next_dawn_state;
   logic                   day_seen;
   logic                   next_day_seen;
   logic [AOSC_MIN_W-1:0]  dawn_time;
   logic [AOSC_MIN_W-1:0]  next_dawn_time;
   logic                   dawn_edge;
   logic [AOSC_MEAS_W-1:0] charge;

   // Previous daylight level; reset to day so a daylight start shows no edge
   always_comb begin
      next_day_seen = is_day;
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         day_seen <= 1'b1;
      end else begin
         day_seen <= next_day_seen;
      end
   end

   // Inputs are synchronous, so the edge may look at them directly
   assign dawn_edge = is_day & ~day_seen;

   always_comb begin
      next_dawn_state = dawn_state;
      next_dawn_time  = dawn_time;
      case (dawn_state)
         AOSC_DAWN_INIT: begin
            // A start in daylight gives no usable dawn
            if (!is_day) begin
               next_dawn_state = AOSC_DAWN_NIGHT;
            end
         end
         AOSC_DAWN_NIGHT: begin
            if (dawn_edge) begin
               next_dawn_state = AOSC_DAWN_KNOWN;
               next_dawn_time  = minute_of_day;
            end
         end
         AOSC_DAWN_KNOWN: begin
            if (dawn_edge) begin
               next_dawn_time = minute_of_day;
            end
         end
         default: begin
            next_dawn_state = AOSC_DAWN_INIT;
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         dawn_state <= AOSC_DAWN_INIT;
         dawn_time  <= AOSC_MIN_RST;
      end else begin
         dawn_state <= next_dawn_state;
         dawn_time  <= next_dawn_time;
      end
   end

   assign dawn_known  = (dawn_state == AOSC_DAWN_KNOWN);
   assign dawn_minute = dawn_time;

   // One unit for all thresholds, chosen by the control mode
   assign charge = ctrl_by_soc ? batt_soc : batt_voltage;

   // One complete set of functions per output
   for (genvar g = 0; g < AOSC_NUM_OUT; g++) begin : g_out

      logic                      ml_on;
      logic                      next_ml_on;
      logic [AOSC_MIN_W-1:0]     ml_end;
      logic [AOSC_MIN_W-1:0]     ml_start;
      logic [AOSC_NUM_TIMER-1:0] tm_on;
      logic [AOSC_NUM_TIMER-1:0] next_tm_on;
      logic                      exc_on;
      logic                      gen_on;
      logic                      dd_low;
      logic [AOSC_FN_W-1:0]      req;
      logic                      auto_on;
      logic                      relay;
      logic                      next_relay;

      // Switch-off point lies the off-delay ahead of the learned dawn
      assign ml_end   = aosc_min_sub(dawn_time, ml_off_delay[g]);
      assign ml_start = aosc_min_sub(ml_end, ml_on_dur[g]);

      always_comb begin
         next_ml_on = ml_on;
         if (!dawn_known || dawn_edge) begin
            next_ml_on = 1'b0;
         end else if (minute_tick) begin
            if (minute_of_day == ml_end) begin
               next_ml_on = 1'b0;
            end else if (minute_of_day == ml_start && !is_day) begin
               // A start minute in daylight is skipped; the window stays dark until its next start minute
               next_ml_on = 1'b1;
            end
         end
      end

      // Reset drops the window; it rearms only at its next start minute
      always_ff @(posedge ref_clk) begin
         if (reset) begin
            ml_on <= 1'b0;
         end else begin
            ml_on <= next_ml_on;
         end
      end

      // Off wins when on and off fall on the same minute of a timer
      always_comb begin
         next_tm_on = tm_on;
         for (int t = 0; t < AOSC_NUM_TIMER; t++) begin
            if (minute_tick) begin
               if (tm_hit(tm_on_day[g][t], tm_on_time[g][t], weekday, minute_of_day)) begin
                  next_tm_on[t] = 1'b1;
               end
               if (tm_hit(tm_off_day[g][t], tm_off_time[g][t], weekday, minute_of_day)) begin
                  next_tm_on[t] = 1'b0;
               end
            end
         end
      end

      // Timer states restart off; a missed on-minute is not replayed
      always_ff @(posedge ref_clk) begin
         if (reset) begin
            tm_on <= '0;
         end else begin
            tm_on <= next_tm_on;
         end
      end

      // High-side window: on at threshold, off below threshold minus hysteresis
      aosc_hyst u_exc (
         .ref_clk  (ref_clk),
         .reset    (reset),
         .update   (charge_update),
         .low_side (1'b0),
         .meas     (charge),
         .thresh   (exc_thresh[g]),
         .hyst     (exc_hyst[g]),
         .active   (exc_on)
      );

      // Low-side window: on below threshold, off at threshold plus hysteresis
      aosc_hyst u_gen (
         .ref_clk  (ref_clk),
         .reset    (reset),
         .update   (charge_update),
         .low_side (1'b1),
         .meas     (charge),
         .thresh   (gen_thresh[g]),
         .hyst     (gen_hyst[g]),
         .active   (gen_on)
      );

      // Same low-side window: trip below threshold, release at plus hysteresis
      aosc_hyst u_dd (
         .ref_clk  (ref_clk),
         .reset    (reset),
         .update   (charge_update),
         .low_side (1'b1),
         .meas     (charge),
         .thresh   (dd_thresh[g]),
         .hyst     (dd_hyst[g]),
         .active   (dd_low)
      );

      always_comb begin
         req                  = '0;
         req[AOSC_FN_MORNING] = ml_on;
         req[AOSC_FN_EXCESS]  = exc_on;
         req[AOSC_FN_GEN]     = gen_on;
         req[AOSC_FN_W-1:AOSC_FN_TIMER0] = tm_on;
      end

      // Enables gate each function before the OR
      assign auto_on = |(req & func_en[g]);

      always_comb begin
         case (out_mode[g])
            AOSC_MODE_ON: begin
               next_relay = 1'b1;
            end
            AOSC_MODE_AUTO: begin
               next_relay = auto_on & ~dd_low;
            end
            default: begin
               // Off, and any unused code, keep the relay open
               next_relay = 1'b0;
            end
         endcase
      end

      // Registered request keeps the relay free of decode glitches
      always_ff @(posedge ref_clk) begin
         if (reset) begin
            relay <= 1'b0;
         end else begin
            relay <= next_relay;
         end
      end

      assign relay_on[g]   = relay;
      assign func_req[g]   = req;
      assign dd_blocked[g] = dd_low;
   end

endmodule : aosc_top

// ===== tb_aosc_top.sv
// Directed testbench of the auxiliary output switch control
`timescale 1ns/100ps
module tb_aosc_top;
   import aosc_pkg::*;
   logic ref_clk = 1'b0, reset = 1'b1, is_day = 1'b1, minute_tick = 1'b0;
   logic charge_update = 1'b0, ctrl_by_soc = 1'b0;
   logic [AOSC_DAY_W-1:0] weekday = '0;
   logic [AOSC_MIN_W-1:0] minute_of_day = '0;
   logic [AOSC_MEAS_W-1:0] batt_voltage = '0, batt_soc = '0;
   logic [AOSC_NUM_OUT-1:0][1:0] out_mode = '0;
   logic [AOSC_NUM_OUT-1:0][AOSC_FN_W-1:0] func_en = '0;
   logic [AOSC_NUM_OUT-1:0][AOSC_MIN_W-1:0] ml_on_dur = '0, ml_off_delay = '0;
   logic [AOSC_NUM_OUT-1:0][AOSC_MEAS_W-1:0] exc_thresh = '0, exc_hyst = '0, gen_thresh = '0;
   logic [AOSC_NUM_OUT-1:0][AOSC_MEAS_W-1:0] gen_hyst = '0, dd_thresh = '0, dd_hyst = '0;
   logic [AOSC_NUM_OUT-1:0][AOSC_NUM_TIMER-1:0][AOSC_NUM_DAY-1:0] tm_on_day = '0, tm_off_day = '0;
   logic [AOSC_NUM_OUT-1:0][AOSC_NUM_TIMER-1:0][AOSC_NUM_DAY-1:0][AOSC_MIN_W-1:0] tm_on_time = '0;
   logic [AOSC_NUM_OUT-1:0][AOSC_NUM_TIMER-1:0][AOSC_NUM_DAY-1:0][AOSC_MIN_W-1:0] tm_off_time = '0;
   wire logic [AOSC_NUM_OUT-1:0] relay_on, dd_blocked, load_on;
   wire logic [AOSC_NUM_OUT-1:0][AOSC_FN_W-1:0] func_req;
   wire logic dawn_known;
   wire logic [AOSC_MIN_W-1:0] dawn_minute;
   // Observed word: out1 excess request, relays, out0 requests
   wire logic [15:0] obs = {5'h00, func_req[1][1], relay_on, func_req[0]};
   wire logic [15:0] dwn = {4'h0, dawn_known, dawn_minute};
   logic [15:0] exp_v;
   int error_cnt = 0;
   int n_checks = 0;

   always #20 ref_clk = ~ref_clk;

   aosc_top u_aosc_top (.ref_clk(ref_clk), .reset(reset), .is_day(is_day),
      .minute_tick(minute_tick), .weekday(weekday), .minute_of_day(minute_of_day),
      .charge_update(charge_update), .ctrl_by_soc(ctrl_by_soc), .batt_voltage(batt_voltage),
      .batt_soc(batt_soc), .out_mode(out_mode), .func_en(func_en), .ml_on_dur(ml_on_dur),
      .ml_off_delay(ml_off_delay), .exc_thresh(exc_thresh), .exc_hyst(exc_hyst),
      .gen_thresh(gen_thresh), .gen_hyst(gen_hyst), .dd_thresh(dd_thresh), .dd_hyst(dd_hyst),
      .tm_on_day(tm_on_day), .tm_on_time(tm_on_time), .tm_off_day(tm_off_day),
      .tm_off_time(tm_off_time), .relay_on(relay_on), .func_req(func_req),
      .dd_blocked(dd_blocked), .dawn_known(dawn_known), .dawn_minute(dawn_minute));

   aosc_load_model u_aosc_load_model (.ref_clk(ref_clk), .relay_on(relay_on), .load_on(load_on));

   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp

   // Sample pulse, then one more edge so the relay has settled too
   task automatic chg(input logic [15:0] v, input logic [15:0] s);
      batt_voltage = v;
      batt_soc = s;
      charge_update = 1'b1;
      @(negedge ref_clk);
      charge_update = 1'b0;
      @(negedge ref_clk);
   endtask : chg

   task automatic tick(input logic [2:0] wd, input logic [10:0] m);
      weekday = wd;
      minute_of_day = m;
      minute_tick = 1'b1;
      @(negedge ref_clk);
      minute_tick = 1'b0;
      @(negedge ref_clk);
   endtask : tick

   task automatic stop_test;
      if (error_cnt == 0 && n_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : stop_test

   initial begin
      repeat (4) @(negedge ref_clk);
      reset = 1'b0;
      @(negedge ref_clk);
      cmp(dwn, 16'h0000);
      out_mode = {2'h3, AOSC_MODE_OFF, AOSC_MODE_ON};
      repeat (2) @(negedge ref_clk);
      cmp(obs, 16'h0080);
      cmp({13'h0000, load_on}, 16'h0001);
      out_mode = {2'h3, AOSC_MODE_OFF, AOSC_MODE_AUTO};
      repeat (2) @(negedge ref_clk);
      cmp(obs, 16'h0000);
      func_en[0] = 7'h02;
      func_en[1] = 7'h02;
      exc_thresh = {16'h0000, 16'h0050, 16'h0064};
      exc_hyst[0] = 16'h000a;
      chg(16'h0063, 16'h0000); cmp(obs, 16'h0400);
      chg(16'h0064, 16'h0000); cmp(obs, 16'h0482);
      chg(16'h005b, 16'h0000); cmp(obs, 16'h0482);
      chg(16'h0059, 16'h0000); cmp(obs, 16'h0400);
      ctrl_by_soc = 1'b1;
      chg(16'h0000, 16'h0064); cmp(obs, 16'h0482);
      chg(16'h00c8, 16'h0000); cmp(obs, 16'h0000);
      ctrl_by_soc = 1'b0;
      batt_voltage = 16'h00c8;
      repeat (2) @(negedge ref_clk);
      cmp(obs, 16'h0000);
      func_en[0] = 7'h04;
      gen_thresh[0] = 16'h0032;
      gen_hyst[0] = 16'h0014;
      chg(16'h0032, 16'h0000); cmp(obs, 16'h0000);
      chg(16'h0031, 16'h0000); cmp(obs, 16'h0084);
      chg(16'h0044, 16'h0000); cmp(obs, 16'h0084);
      chg(16'h0046, 16'h0000); cmp(obs, 16'h0000);
      dd_thresh[0] = 16'h001e;
      dd_hyst[0] = 16'h0005;
      chg(16'h001d, 16'h0000); cmp(obs, 16'h0004);
      cmp({13'h0000, dd_blocked}, 16'h0001);
      chg(16'h0022, 16'h0000); cmp(obs, 16'h0004);
      chg(16'h0023, 16'h0000); cmp(obs, 16'h0084);
      func_en[0] = 7'h06;
      chg(16'h0078, 16'h0000); cmp(obs, 16'h0482);
      chg(16'h0046, 16'h0000); cmp(obs, 16'h0000);
      for (int t = 0; t < AOSC_NUM_TIMER; t++) begin
         func_en[0] = 7'h08 << t;
         tm_on_day[0][t] = 7'h03;
         tm_on_time[0][t][0] = 11'h0c8;
         tm_on_time[0][t][1] = 11'h064 + 11'(t);
         tm_off_day[0][t] = 7'h04;
         tm_off_time[0][t][2] = 11'h032;
         exp_v = 16'h0080 | (16'h0008 << t);
         tick(3'h0, 11'h064 + 11'(t)); cmp(obs, 16'h0000);
         tick(3'h1, 11'h064 + 11'(t)); cmp(obs, exp_v);
         tick(3'h2, 11'h031); cmp(obs, exp_v);
         tick(3'h2, 11'h032); cmp(obs, 16'h0000);
      end
      // Morning light: start 360, end 390 once dawn is learned at 400
      func_en[0] = 7'h01;
      ml_on_dur[0] = 11'h01e;
      ml_off_delay[0] = 11'h00a;
      is_day = 1'b0;
      repeat (2) @(negedge ref_clk);
      tick(3'h3, 11'h168); cmp(obs, 16'h0000);
      minute_of_day = 11'h190;
      is_day = 1'b1;
      repeat (3) @(negedge ref_clk);
      cmp(dwn, 16'h0990);
      is_day = 1'b0;
      repeat (2) @(negedge ref_clk);
      tick(3'h3, 11'h168); cmp(obs, 16'h0081);
      tick(3'h3, 11'h17c); cmp(obs, 16'h0081);
      tick(3'h3, 11'h186); cmp(obs, 16'h0000);
      tick(3'h3, 11'h168); cmp(obs, 16'h0081);
      minute_of_day = 11'h172;
      is_day = 1'b1;
      repeat (3) @(negedge ref_clk);
      cmp(obs, 16'h0000);
      cmp(dwn, 16'h0972);
      stop_test();
   end
endmodule : tb_aosc_top
